// ==== act_pkg.sv ====
package act_pkg;
   localparam int ACT_ADDR_W  = 12;
   localparam int ACT_DATA_W  = 8;
   localparam int ACT_TIME_W  = 8;
   localparam int ACT_OFS_W   = 12;
   localparam int ACT_OREG_W  = 16;
   localparam int ACT_N_TIME  = 2;
   localparam int ACT_N_OFS   = 5;

   // Timing trim indexes and byte addresses
   localparam int ACT_T_CORE_A_SINGLE_IB = 0;
   localparam int ACT_T_CORE_B_SINGLE_IB = 1;
   localparam logic [ACT_ADDR_W-1:0] ACT_TIME_ADDR [ACT_N_TIME] = '{12'h31a, 12'h31b};

   // Offset trim indexes and base byte addresses, low byte at base, high byte at base plus one
   localparam int ACT_O_CORE_A_DUAL_IA   = 0;
   localparam int ACT_O_CORE_A_DUAL_IB   = 1;
   localparam int ACT_O_CORE_A_SINGLE_IA = 2;
   localparam int ACT_O_CORE_A_SINGLE_IB = 3;
   localparam int ACT_O_CORE_B_IA        = 4;
   localparam logic [ACT_ADDR_W-1:0] ACT_OFS_ADDR [ACT_N_OFS] =
      '{12'h344, 12'h346, 12'h348, 12'h34a, 12'h34c};
   localparam logic [ACT_ADDR_W-1:0] ACT_HI_BYTE_STEP = 12'h001;

   // Field layout of a 16-bit offset trim
   localparam int ACT_OFS_LSB = 0;
   localparam int ACT_OFS_MSB = 11;
   localparam int ACT_RSV_LSB = 12;
   localparam int ACT_RSV_MSB = 15;

   // Reset values
   localparam logic [ACT_TIME_W-1:0] ACT_TIME_RST = 8'h00;
   localparam logic [ACT_OREG_W-1:0] ACT_OREG_RST = 16'h0000;
   localparam logic [ACT_OFS_W-1:0]  ACT_OFS_OFF  = 12'h000;
   localparam logic [ACT_DATA_W-1:0] ACT_RD_NONE  = 8'h00;
endpackage

// ==== act_trim_select.sv ====
`timescale 1ns/1ps
module act_trim_select
   import act_pkg::*;
(
   input  wire logic                                  clk,
   input  wire logic                                  rst,
   input  wire logic                                  single_mode,
   input  wire logic                                  fg_cal_en,
   input  wire logic                                  core_a_samples_second,
   input  wire logic                                  core_b_samples_second,
   input  wire logic                                  core_a_phase_90,
   input  wire logic [act_pkg::ACT_N_TIME-1:0][act_pkg::ACT_TIME_W-1:0] time_trim,
   input  wire logic [act_pkg::ACT_N_OFS-1:0][act_pkg::ACT_OREG_W-1:0]  ofs_trim,
   output logic [act_pkg::ACT_TIME_W-1:0]             core_a_timing_trim,
   output logic                                       core_a_timing_valid,
   output logic [act_pkg::ACT_TIME_W-1:0]             core_b_timing_trim,
   output logic                                       core_b_timing_valid,
   output logic [act_pkg::ACT_OFS_W-1:0]              core_a_offset_trim,
   output logic                                       core_a_offset_valid,
   output logic [act_pkg::ACT_OFS_W-1:0]              core_b_offset_trim,
   output logic                                       core_b_offset_valid
);
   import act_pkg::*;

   // Unselected values drive zero so a stale trim never reaches a core
   always_ff @(posedge clk) begin
      if (rst) begin
         core_a_timing_trim  <= ACT_TIME_RST;
         core_a_timing_valid <= 1'b0;
      end else if (fg_cal_en && single_mode && core_a_samples_second) begin
         core_a_timing_trim  <= time_trim[ACT_T_CORE_A_SINGLE_IB]; // R1
         core_a_timing_valid <= 1'b1;
      end else begin
         core_a_timing_trim  <= ACT_TIME_RST; // R10
         core_a_timing_valid <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         core_b_timing_trim  <= ACT_TIME_RST;
         core_b_timing_valid <= 1'b0;
      end else if (fg_cal_en && single_mode && core_b_samples_second) begin
         core_b_timing_trim  <= time_trim[ACT_T_CORE_B_SINGLE_IB]; // R2
         core_b_timing_valid <= 1'b1;
      end else begin
         core_b_timing_trim  <= ACT_TIME_RST; // R10
         core_b_timing_valid <= 1'b0;
      end
   end

   // Phase 90 takes priority: it is the only selector that names the clock phase
   always_ff @(posedge clk) begin
      if (rst) begin
         core_a_offset_trim  <= ACT_OFS_OFF;
         core_a_offset_valid <= 1'b0;
      end else if (!fg_cal_en) begin
         core_a_offset_trim  <= ACT_OFS_OFF; // R10
         core_a_offset_valid <= 1'b0;
      end else if (core_a_phase_90 && core_a_samples_second) begin
         core_a_offset_trim  <= ofs_trim[ACT_O_CORE_A_SINGLE_IB][ACT_OFS_MSB:ACT_OFS_LSB]; // R6
         core_a_offset_valid <= 1'b1;
      end else if (!single_mode && !core_a_samples_second) begin
         core_a_offset_trim  <= ofs_trim[ACT_O_CORE_A_DUAL_IA][ACT_OFS_MSB:ACT_OFS_LSB]; // R3
         core_a_offset_valid <= 1'b1;
      end else if (!single_mode && core_a_samples_second) begin
         core_a_offset_trim  <= ofs_trim[ACT_O_CORE_A_DUAL_IB][ACT_OFS_MSB:ACT_OFS_LSB]; // R4
         core_a_offset_valid <= 1'b1;
      end else if (single_mode && !core_a_samples_second) begin
         core_a_offset_trim  <= ofs_trim[ACT_O_CORE_A_SINGLE_IA][ACT_OFS_MSB:ACT_OFS_LSB]; // R5
         core_a_offset_valid <= 1'b1;
      end else begin
         core_a_offset_trim  <= ACT_OFS_OFF; // R10
         core_a_offset_valid <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         core_b_offset_trim  <= ACT_OFS_OFF;
         core_b_offset_valid <= 1'b0;
      end else if (fg_cal_en && !core_b_samples_second) begin
         core_b_offset_trim  <= ofs_trim[ACT_O_CORE_B_IA][ACT_OFS_MSB:ACT_OFS_LSB]; // R7
         core_b_offset_valid <= 1'b1;
      end else begin
         core_b_offset_trim  <= ACT_OFS_OFF; // R10
         core_b_offset_valid <= 1'b0;
      end
   end
endmodule

// ==== act_trim_bank.sv ====
`timescale 1ns/1ps
// Function
// R1: Core A single-channel second-input timing trim at 0x31a, applied with foreground cal.
// R2: Core B single-channel second-input timing trim at 0x31b, applied with foreground cal.
// R3: Core A dual-channel first-input 12-bit offset trim at 0x344.
// R4: Core A dual-channel second-input 12-bit offset trim at 0x346.
// R5: Core A single-channel first-input 12-bit offset trim at 0x348.
// R6: Core A second-input 90-degree phase offset trim at 0x34a.
// R7: Core B first-input offset trim at 0x34c, default loaded from fuses.
// R8: Offset trim bits 15:12 reserved, read/write, reset to zero.
// R9: Timing trims shift sampling instant; fuse defaults readable and writable.
// R10: Trims whose core, mode, input or calibration condition fails are not applied.
module act_trim_bank
   import act_pkg::*;
(
   input  wire logic                           clk,
   input  wire logic                           rst,
   input  wire logic [act_pkg::ACT_ADDR_W-1:0] reg_addr,
   input  wire logic                           reg_wr_en,
   input  wire logic [act_pkg::ACT_DATA_W-1:0] reg_wr_data,
   input  wire logic                           reg_rd_en,
   output logic [act_pkg::ACT_DATA_W-1:0]      reg_rd_data,
   output logic                                reg_rd_valid,
   input  wire logic                           fuse_load,
   input  wire logic [act_pkg::ACT_TIME_W-1:0] fuse_core_a_single_input_b_timing_trim,
   input  wire logic [act_pkg::ACT_TIME_W-1:0] fuse_core_b_single_input_b_timing_trim,
   input  wire logic [act_pkg::ACT_OFS_W-1:0]  fuse_core_a_dual_input_a_offset_trim,
   input  wire logic [act_pkg::ACT_OFS_W-1:0]  fuse_core_a_dual_input_b_offset_trim,
   input  wire logic [act_pkg::ACT_OFS_W-1:0]  fuse_core_a_single_input_a_offset_trim,
   input  wire logic [act_pkg::ACT_OFS_W-1:0]  fuse_core_a_single_input_b_offset_trim,
   input  wire logic [act_pkg::ACT_OFS_W-1:0]  fuse_core_b_input_a_offset_trim,
   input  wire logic                           single_mode,
   input  wire logic                           fg_cal_en,
   input  wire logic                           core_a_samples_second,
   input  wire logic                           core_b_samples_second,
   input  wire logic                           core_a_phase_90,
   output logic [act_pkg::ACT_TIME_W-1:0]      core_a_timing_trim,
   output logic                                core_a_timing_valid,
   output logic [act_pkg::ACT_TIME_W-1:0]      core_b_timing_trim,
   output logic                                core_b_timing_valid,
   output logic [act_pkg::ACT_OFS_W-1:0]       core_a_offset_trim,
   output logic                                core_a_offset_valid,
   output logic [act_pkg::ACT_OFS_W-1:0]       core_b_offset_trim,
   output logic                                core_b_offset_valid
);
   import act_pkg::*;

   logic [ACT_N_TIME-1:0][ACT_TIME_W-1:0] time_reg;
   logic [ACT_N_OFS-1:0][ACT_OREG_W-1:0]  ofs_reg;
   logic [ACT_N_TIME-1:0][ACT_TIME_W-1:0] fuse_time;
   logic [ACT_N_OFS-1:0][ACT_OFS_W-1:0]   fuse_ofs;
   logic [ACT_DATA_W-1:0]                 rd_data_next;

   assign fuse_time[ACT_T_CORE_A_SINGLE_IB] = fuse_core_a_single_input_b_timing_trim;
   assign fuse_time[ACT_T_CORE_B_SINGLE_IB] = fuse_core_b_single_input_b_timing_trim;
   assign fuse_ofs[ACT_O_CORE_A_DUAL_IA]    = fuse_core_a_dual_input_a_offset_trim;
   assign fuse_ofs[ACT_O_CORE_A_DUAL_IB]    = fuse_core_a_dual_input_b_offset_trim;
   assign fuse_ofs[ACT_O_CORE_A_SINGLE_IA]  = fuse_core_a_single_input_a_offset_trim;
   assign fuse_ofs[ACT_O_CORE_A_SINGLE_IB]  = fuse_core_a_single_input_b_offset_trim;
   assign fuse_ofs[ACT_O_CORE_B_IA]         = fuse_core_b_input_a_offset_trim;

   // Software write beats a fuse load in the same cycle: the later intent wins
   genvar gi;
   generate
      for (gi = 0; gi < ACT_N_TIME; gi++) begin : g_time
         always_ff @(posedge clk) begin
            if (rst) begin
               time_reg[gi] <= ACT_TIME_RST;
            end else if (reg_wr_en && reg_addr == ACT_TIME_ADDR[gi]) begin
               time_reg[gi] <= reg_wr_data; // R9
            end else if (fuse_load) begin
               time_reg[gi] <= fuse_time[gi]; // R9
            end
         end
      end

      for (gi = 0; gi < ACT_N_OFS; gi++) begin : g_ofs
         always_ff @(posedge clk) begin
            if (rst) begin
               ofs_reg[gi] <= ACT_OREG_RST; // R8
            end else if (reg_wr_en && reg_addr == ACT_OFS_ADDR[gi]) begin
               ofs_reg[gi][ACT_DATA_W-1:0] <= reg_wr_data;
            end else if (reg_wr_en && reg_addr == ACT_OFS_ADDR[gi] + ACT_HI_BYTE_STEP) begin
               ofs_reg[gi][ACT_OREG_W-1:ACT_DATA_W] <= reg_wr_data; // R8
            end else if (fuse_load) begin
               // Fuses carry no reserved bits, so those stay as software left them
               ofs_reg[gi][ACT_OFS_MSB:ACT_OFS_LSB] <= fuse_ofs[gi]; // R7
            end
         end
      end
   endgenerate

   // Unmapped byte addresses read as zero
   always_comb begin
      rd_data_next = ACT_RD_NONE;
      for (int i = 0; i < ACT_N_TIME; i++) begin
         if (reg_addr == ACT_TIME_ADDR[i]) begin
            rd_data_next = time_reg[i]; // R9
         end
      end
      for (int i = 0; i < ACT_N_OFS; i++) begin
         if (reg_addr == ACT_OFS_ADDR[i]) begin
            rd_data_next = ofs_reg[i][ACT_DATA_W-1:0];
         end else if (reg_addr == ACT_OFS_ADDR[i] + ACT_HI_BYTE_STEP) begin
            rd_data_next = ofs_reg[i][ACT_OREG_W-1:ACT_DATA_W]; // R8
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rd_data  <= ACT_RD_NONE;
         reg_rd_valid <= 1'b0;
      end else begin
         reg_rd_valid <= reg_rd_en;
         if (reg_rd_en) begin
            reg_rd_data <= rd_data_next;
         end
      end
   end

   // Selection is registered inside, one cycle behind mode or register changes
   act_trim_select u_select (
      .clk                   (clk),
      .rst                   (rst),
      .single_mode           (single_mode),
      .fg_cal_en             (fg_cal_en),
      .core_a_samples_second (core_a_samples_second),
      .core_b_samples_second (core_b_samples_second),
      .core_a_phase_90       (core_a_phase_90),
      .time_trim             (time_reg),
      .ofs_trim              (ofs_reg),
      .core_a_timing_trim    (core_a_timing_trim),
      .core_a_timing_valid   (core_a_timing_valid),
      .core_b_timing_trim    (core_b_timing_trim),
      .core_b_timing_valid   (core_b_timing_valid),
      .core_a_offset_trim    (core_a_offset_trim),
      .core_a_offset_valid   (core_a_offset_valid),
      .core_b_offset_trim    (core_b_offset_trim),
      .core_b_offset_valid   (core_b_offset_valid)
   );
endmodule

// ==== act_trim_bank_sva.sv ====
`timescale 1ns/1ps
module act_trim_bank_sva
   import act_pkg::*;
(
   input wire logic                            clk,
   input wire logic                            rst,
   input wire logic                            reg_rd_en,
   input wire logic [act_pkg::ACT_DATA_W-1:0]  reg_rd_data,
   input wire logic                            reg_rd_valid,
   input wire logic                            single_mode,
   input wire logic                            fg_cal_en,
   input wire logic                            core_a_samples_second,
   input wire logic                            core_b_samples_second,
   input wire logic                            core_a_phase_90,
   input wire logic                            core_a_timing_valid,
   input wire logic                            core_b_timing_valid,
   input wire logic [act_pkg::ACT_OFS_W-1:0]   core_a_offset_trim,
   input wire logic                            core_a_offset_valid,
   input wire logic                            core_b_offset_valid
);
   import act_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   AST_RD_VALID: assert property (!$past(rst) |-> reg_rd_valid == $past(reg_rd_en)) else $error("read valid late");
   AST_RD_HOLD: assert property (!$past(rst) && !$past(reg_rd_en) |-> $stable(reg_rd_data)) else $error("read data moved");
   AST_A_TIME: assert property (core_a_timing_valid
      |-> $past(fg_cal_en & single_mode & core_a_samples_second)) else $error("core a timing applied wrongly");
   AST_B_TIME: assert property (core_b_timing_valid
      |-> $past(fg_cal_en & single_mode & core_b_samples_second)) else $error("core b timing applied wrongly");
   AST_A_DUAL: assert property (!$past(rst) && $past(fg_cal_en & ~single_mode) |-> core_a_offset_valid)
      else $error("dual offset missing");
   AST_A_P90: assert property (!$past(rst) && $past(fg_cal_en & core_a_phase_90 & core_a_samples_second)
      |-> core_a_offset_valid) else $error("phase offset missing");
   AST_B_OFS: assert property (!$past(rst)
      |-> core_b_offset_valid == $past(fg_cal_en & ~core_b_samples_second)) else $error("core b offset wrong");
   AST_CAL_OFF: assert property ($past(!fg_cal_en) |-> !(core_a_timing_valid | core_b_timing_valid
      | core_a_offset_valid | core_b_offset_valid)) else $error("trim applied without cal");
   AST_A_ZERO: assert property (!core_a_offset_valid |-> core_a_offset_trim == '0) else $error("stale offset");
endmodule

// ==== act_trim_bank_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module act_trim_bank_tb_top;
   import act_pkg::*;
   logic                  clk = 1'b0, rst = 1'b1, reg_wr_en = 1'b0, reg_rd_en = 1'b0, fuse_load = 1'b0;
   logic                  single_mode = 1'b0, fg_cal_en = 1'b0, core_a_samples_second = 1'b0;
   logic                  core_b_samples_second = 1'b0, core_a_phase_90 = 1'b0, reg_rd_valid;
   logic                  core_a_timing_valid, core_b_timing_valid, core_a_offset_valid, core_b_offset_valid;
   logic [ACT_ADDR_W-1:0] reg_addr = 12'h000;
   logic [ACT_DATA_W-1:0] reg_wr_data = 8'h00, reg_rd_data;
   logic [ACT_TIME_W-1:0] core_a_timing_trim, core_b_timing_trim;
   logic [ACT_TIME_W-1:0] fuse_core_a_single_input_b_timing_trim, fuse_core_b_single_input_b_timing_trim;
   logic [ACT_OFS_W-1:0]  core_a_offset_trim, core_b_offset_trim;
   logic [ACT_OFS_W-1:0]  fuse_core_a_dual_input_a_offset_trim, fuse_core_a_dual_input_b_offset_trim;
   logic [ACT_OFS_W-1:0]  fuse_core_a_single_input_a_offset_trim, fuse_core_a_single_input_b_offset_trim;
   logic [ACT_OFS_W-1:0]  fuse_core_b_input_a_offset_trim;
   logic [ACT_TIME_W-1:0] ft [2] = '{8'h3c, 8'hc3};
   logic [ACT_OFS_W-1:0]  fo [5] = '{12'h1a5, 12'h2b6, 12'h3c7, 12'h4d8, 12'h5e9};
   logic [7:0]            mem [12] = '{default: 8'h00};
   int                    fail_count = 0, comparisons = 0;
   assign fuse_core_a_single_input_b_timing_trim = ft[0];
   assign fuse_core_b_single_input_b_timing_trim = ft[1];
   assign fuse_core_a_dual_input_a_offset_trim = fo[0];
   assign fuse_core_a_dual_input_b_offset_trim = fo[1];
   assign fuse_core_a_single_input_a_offset_trim = fo[2];
   assign fuse_core_a_single_input_b_offset_trim = fo[3];
   assign fuse_core_b_input_a_offset_trim = fo[4];
   act_trim_bank act_trim_bank_inst (.*);
   initial forever #12.5 clk = ~clk;
   // Byte map: two timing trims, then low and high byte of each offset trim
   function automatic logic [11:0] ad(input int i);
      return (i < 2) ? 12'(12'h31a + i) : 12'(12'h344 + i - 2);
   endfunction
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic f);
      reg_addr <= a;
      reg_wr_data <= d;
      reg_wr_en <= 1'b1;
      fuse_load <= f;
      @(posedge clk) #1 reg_wr_en <= 1'b0;
      fuse_load <= 1'b0;
      @(posedge clk) #1;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      reg_addr <= a;
      reg_rd_en <= 1'b1;
      @(posedge clk) #1 reg_rd_en <= 1'b0;
      `CHK({reg_rd_valid, reg_rd_data}, {1'b1, e})
      @(posedge clk) #1;
   endtask
   task automatic rdall;
      for (int i = 0; i < 12; i++) rd(ad(i), mem[i]);
   endtask
   // Mode bits: single, cal, a second, b second, phase 90; index -1 means no offset applied
   task automatic md(input logic [4:0] m, input logic at, input logic bt, input int ai, input int bi);
      {single_mode, fg_cal_en, core_a_samples_second, core_b_samples_second, core_a_phase_90} <= m;
      repeat (2) @(posedge clk);
      #1;
      `CHK({core_a_timing_valid, core_a_timing_trim}, at ? {1'b1, mem[0]} : 9'h000)
      `CHK({core_b_timing_valid, core_b_timing_trim}, bt ? {1'b1, mem[1]} : 9'h000)
      `CHK({core_a_offset_valid, core_a_offset_trim}, (ai < 0) ? 13'h0000 : {1'b1, mem[2*ai+3][3:0], mem[2*ai+2]})
      `CHK({core_b_offset_valid, core_b_offset_trim}, (bi < 0) ? 13'h0000 : {1'b1, mem[11][3:0], mem[10]})
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      #1 rst <= 1'b0;
      @(posedge clk) #1;
      rdall();
      md(5'b10111, 0, 0, -1, -1);
      $display("reset test done");
      for (int i = 0; i < 12; i++) begin
         mem[i] = 8'(8'h91 + i * 8'h17);
         wr(ad(i), mem[i], 1'b0);
      end
      rdall();
      wr(12'h31c, 8'hff, 1'b0);
      rd(12'h31c, 8'h00);
      rd(12'h343, 8'h00);
      $display("register test done");
      md(5'b01000, 0, 0, 0, 4);
      md(5'b01110, 0, 0, 1, -1);
      md(5'b11010, 0, 1, 2, -1);
      md(5'b11101, 1, 0, 3, 4);
      md(5'b01101, 0, 0, 3, 4);
      md(5'b11100, 1, 0, -1, 4);
      md(5'b10111, 0, 0, -1, -1);
      $display("mode test done");
      // Write in the load cycle keeps its byte; reserved nibbles are not loaded
      wr(12'h31a, 8'h77, 1'b1);
      mem[0] = 8'h77;
      mem[1] = ft[1];
      for (int k = 0; k < 5; k++) begin
         mem[2*k+2] = fo[k][7:0];
         mem[2*k+3] = {mem[2*k+3][7:4], fo[k][11:8]};
      end
      rdall();
      md(5'b11101, 1, 0, 3, 4);
      $display("fuse test done");
      // Mid-run reset must clear software and fuse values alike
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      #1 rst <= 1'b0;
      @(posedge clk) #1;
      mem = '{default: 8'h00};
      rdall();
      md(5'b11101, 1, 0, 3, 4);
      $display("mid-run reset test done");
      print_verdict();
   end
   initial begin
      #50us;
      $display("wrong value at %0t: watchdog expired", $time);
      fail_count++;
      print_verdict();
   end
endmodule
bind act_trim_bank act_trim_bank_sva act_trim_bank_sva_inst (.*);
